// [verilog/tcc_pkg.sv]
/*
   Shared constants for the 16-bit capture/compare timer: mode codes,
   prescaler field positions, count clock selection codes and edge codes.
   Assumes the consumer imports the whole package.
*/
`default_nettype none

package tcc_pkg;

   // Widths
   localparam int unsigned TCC_CNT_W  = 16;
   localparam int unsigned TCC_PRE_W  = 8;

   // Reset values, count increment and count maximum
   localparam logic [15:0] TCC_CNT_RST  = 16'h0000;
   localparam logic [15:0] TCC_CC_RST   = 16'h0000;
   localparam logic [7:0]  TCC_PRE_RST  = 8'h00;
   localparam logic [15:0] TCC_CNT_ONE  = 16'h0001;
   localparam logic [15:0] TCC_CNT_MAX  = 16'hffff;

   // Operating mode codes on the mode_control_register port
   localparam logic [2:0] TCC_MC_STOP     = 3'h0;
   localparam logic [2:0] TCC_MC_INTERVAL = 3'h1;
   localparam logic [2:0] TCC_MC_PPG      = 3'h2;
   localparam logic [2:0] TCC_MC_CAP_ONE  = 3'h3;
   localparam logic [2:0] TCC_MC_CAP_PINS = 3'h4;
   localparam logic [2:0] TCC_MC_CAP_TWO  = 3'h5;
   localparam logic [2:0] TCC_MC_RESTART  = 3'h6;

   // Field positions in prescaler_mode_a
   localparam int unsigned TCC_CKS_LO     = 0;
   localparam int unsigned TCC_CKS_HI     = 1;
   localparam int unsigned TCC_ES_A_LO    = 4;
   localparam int unsigned TCC_ES_A_HI    = 5;
   localparam int unsigned TCC_ES_B_LO    = 6;
   localparam int unsigned TCC_ES_B_HI    = 7;
   // Position of clock_select_high_bit in prescaler_mode_b
   localparam int unsigned TCC_CKS_TOP    = 0;

   // Count clock selection codes
   localparam logic [2:0] TCC_CK_DIV2     = 3'h0;
   localparam logic [2:0] TCC_CK_DIV16    = 3'h1;
   localparam logic [2:0] TCC_CK_WATCH    = 3'h2;
   localparam logic [2:0] TCC_CK_TRIG_A   = 3'h3;
   localparam logic [2:0] TCC_CK_DIV4     = 3'h4;
   localparam logic [2:0] TCC_CK_DIV64    = 3'h5;
   localparam logic [2:0] TCC_CK_DIV256   = 3'h6;

   // Prescaler masks: a tick fires when the masked bits are all ones
   localparam logic [7:0] TCC_MASK_DIV2   = 8'h01;
   localparam logic [7:0] TCC_MASK_DIV4   = 8'h03;
   localparam logic [7:0] TCC_MASK_DIV16  = 8'h0f;
   localparam logic [7:0] TCC_MASK_DIV64  = 8'h3f;
   localparam logic [7:0] TCC_MASK_DIV256 = 8'hff;

   // Edge select codes
   localparam logic [1:0] TCC_ES_FALL     = 2'h0;
   localparam logic [1:0] TCC_ES_RISE     = 2'h1;
   localparam logic [1:0] TCC_ES_BOTH     = 2'h3;

   // Operating modes, one-hot
   typedef enum logic [6:0]
   {
      TCC_STOP     = 7'h01,
      TCC_INTERVAL = 7'h02,
      TCC_PPG      = 7'h04,
      TCC_CAP_ONE  = 7'h08,
      TCC_CAP_PINS = 7'h10,
      TCC_CAP_TWO  = 7'h20,
      TCC_RESTART  = 7'h40
   } tcc_mode_t;

endpackage

`default_nettype wire

// [verilog/tcc_edge_filter.sv]
/*
   Noise filter and edge detector for one trigger input.
   Assumes the input is synchronous to clock and that sample_tick is a
   one-cycle strobe at the sampling rate.
*/
`default_nettype none

module tcc_edge_filter
(
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic sample_tick,
   input  wire logic pin,
   output var  logic rise,
   output var  logic fall
);
   import tcc_pkg::*;

   logic samp_r;
   logic level_r;

   // Last sample taken at the sampling strobe
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         samp_r <= 1'b0;
      else if (sample_tick)
         samp_r <= pin;
   end

   // Level moves only after two equal samples; shorter glitches are lost
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         level_r <= 1'b0;
      else if (sample_tick && (samp_r == pin))
         level_r <= pin;
   end

   // One-cycle pulses on each change of the filtered level
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rise <= 1'b0;
         fall <= 1'b0;
      end
      else
      begin
         rise <= sample_tick && (samp_r == pin) && pin && !level_r;
         fall <= sample_tick && (samp_r == pin) && !pin && level_r;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);

   a_filter_two_samples: assert property (rise |-> $past(samp_r) && $past(pin) && !$past(level_r))
      else $error("rise without two high samples");
   a_filter_fall_two: assert property (fall |-> !$past(samp_r) && !$past(pin) && $past(level_r))
      else $error("fall without two low samples");

endmodule

`default_nettype wire

// [verilog/tcc_timer.sv]
/*
   16-bit timer/event counter with two capture/compare registers: interval
   timer, pulse generator and four pulse width measurement variants.
   Assumes all inputs are synchronous to clock and that software changes
   mode, prescaler and edge fields only while the timer is stopped.
*/
`default_nettype none

module tcc_timer
(
   input  wire logic                           clock,
   input  wire logic                           rst_b,
   input  wire logic [2:0]                     mode_control_register,
   input  wire logic [7:0]                     prescaler_mode_a,
   input  wire logic [7:0]                     prescaler_mode_b,
   input  wire logic                           compare_a_write,
   input  wire logic [tcc_pkg::TCC_CNT_W-1:0]  compare_a_data,
   input  wire logic                           compare_b_write,
   input  wire logic [tcc_pkg::TCC_CNT_W-1:0]  compare_b_data,
   input  wire logic                           trigger_input_a,
   input  wire logic                           trigger_input_b,
   input  wire logic                           watch_timer_interrupt,
   output var  logic [tcc_pkg::TCC_CNT_W-1:0]  count_register,
   output var  logic [tcc_pkg::TCC_CNT_W-1:0]  compare_capture_a,
   output var  logic [tcc_pkg::TCC_CNT_W-1:0]  compare_capture_b,
   output var  logic                           match_a_interrupt,
   output var  logic                           capture_b_interrupt,
   output var  logic                           timer_output_pin
);
   import tcc_pkg::*;

   tcc_mode_t          mode_r;
   tcc_mode_t          mode_nxt;
   logic [7:0]         pre_r;
   logic [2:0]         clk_sel;
   logic               div2_tick;
   logic               cnt_tick;
   logic               samp_tick;
   logic               a_rise;
   logic               a_fall;
   logic               b_rise;
   logic               b_fall;
   logic               a_edge_lo;
   logic               a_edge_hi;
   logic               b_edge_hi;
   logic               a_opposite;
   logic [15:0]        count_r;
   logic [15:0]        count_nxt;
   logic               match_hit;
   logic [1:0]         es_a;
   logic [1:0]         es_b;

   // Edge select decode; code 10 never yields a valid edge
   function automatic logic edge_ok(input logic [1:0] es, input logic rise, input logic fall);
      logic ok;
      ok = 1'b0;
      if (es == TCC_ES_FALL)
         ok = fall;
      else if (es == TCC_ES_RISE)
         ok = rise;
      else if (es == TCC_ES_BOTH)
         ok = rise || fall;
      return ok;
   endfunction

   // Prescaler tick for a power-of-two divisor
   function automatic logic div_tick(input logic [7:0] pre, input logic [7:0] mask);
      return (pre & mask) == mask;
   endfunction

   // Mode code decode; unused codes fall back to stop
   always_comb
   begin
      mode_nxt = TCC_STOP;
      unique case (mode_control_register)
         TCC_MC_INTERVAL: mode_nxt = TCC_INTERVAL;
         TCC_MC_PPG:      mode_nxt = TCC_PPG;
         TCC_MC_CAP_ONE:  mode_nxt = TCC_CAP_ONE;
         TCC_MC_CAP_PINS: mode_nxt = TCC_CAP_PINS;
         TCC_MC_CAP_TWO:  mode_nxt = TCC_CAP_TWO;
         TCC_MC_RESTART:  mode_nxt = TCC_RESTART;
         default:         mode_nxt = TCC_STOP;
      endcase
   end

   // Mode register; the counter trusts software to switch only when stopped
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         mode_r <= TCC_STOP;
      else
         mode_r <= mode_nxt;
   end

   // Free prescaler on the peripheral clock
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         pre_r <= TCC_PRE_RST;
      else
         pre_r <= pre_r + 8'h01;
   end

   // Count clock selection from the split three-bit field
   assign clk_sel   = {prescaler_mode_b[TCC_CKS_TOP], prescaler_mode_a[TCC_CKS_HI], prescaler_mode_a[TCC_CKS_LO]};
   assign div2_tick = div_tick(pre_r, TCC_MASK_DIV2);
   assign es_a      = prescaler_mode_a[TCC_ES_A_HI:TCC_ES_A_LO];
   assign es_b      = prescaler_mode_a[TCC_ES_B_HI:TCC_ES_B_LO];

   always_comb
   begin
      cnt_tick  = 1'b0;
      samp_tick = 1'b0;
      unique case (clk_sel)
         TCC_CK_DIV2:   cnt_tick = div2_tick;
         TCC_CK_DIV16:  cnt_tick = div_tick(pre_r, TCC_MASK_DIV16);
         TCC_CK_WATCH:  cnt_tick = watch_timer_interrupt;
         TCC_CK_TRIG_A: cnt_tick = edge_ok(es_a, a_rise, a_fall);
         TCC_CK_DIV4:   cnt_tick = div_tick(pre_r, TCC_MASK_DIV4);
         TCC_CK_DIV64:  cnt_tick = div_tick(pre_r, TCC_MASK_DIV64);
         TCC_CK_DIV256: cnt_tick = div_tick(pre_r, TCC_MASK_DIV256);
         default:       cnt_tick = 1'b0; // Prohibited code freezes the count
      endcase
      // An external count clock cannot sample itself, so fall back to /2
      samp_tick = (clk_sel == TCC_CK_TRIG_A) ? div2_tick : cnt_tick;
   end

   // Noise filters on both trigger inputs
   tcc_edge_filter u_filt_a
   (
      .clock       (clock),
      .rst_b       (rst_b),
      .sample_tick (samp_tick),
      .pin         (trigger_input_a),
      .rise        (a_rise),
      .fall        (a_fall)
   );

   tcc_edge_filter u_filt_b
   (
      .clock       (clock),
      .rst_b       (rst_b),
      .sample_tick (samp_tick),
      .pin         (trigger_input_b),
      .rise        (b_rise),
      .fall        (b_fall)
   );

   // Valid edges per field; the opposite edge is undefined for "both"
   assign a_edge_lo  = edge_ok(es_a, a_rise, a_fall);
   assign a_edge_hi  = edge_ok(es_b, a_rise, a_fall);
   assign b_edge_hi  = edge_ok(es_b, b_rise, b_fall);
   assign a_opposite = (es_a == TCC_ES_FALL) ? a_rise : ((es_a == TCC_ES_RISE) ? a_fall : 1'b0);

   // Next count and compare match
   always_comb
   begin
      count_nxt = count_r;
      match_hit = 1'b0;
      unique case (mode_r)
         TCC_STOP:
            count_nxt = TCC_CNT_RST;
         TCC_INTERVAL, TCC_PPG:
            if (cnt_tick)
            begin
               if (count_r == compare_capture_a)
               begin
                  count_nxt = TCC_CNT_RST;
                  match_hit = 1'b1;
               end
               else
                  count_nxt = count_r + TCC_CNT_ONE;
            end
         TCC_RESTART:
            if (a_edge_lo)
               count_nxt = TCC_CNT_RST;
            else if (cnt_tick)
               count_nxt = count_r + TCC_CNT_ONE;
         TCC_CAP_ONE, TCC_CAP_PINS, TCC_CAP_TWO:
            if (cnt_tick)
               count_nxt = count_r + TCC_CNT_ONE;
      endcase
   end

   // Count register
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         count_r <= TCC_CNT_RST;
      else
         count_r <= count_nxt;
   end

   assign count_register = count_r;

   // Register A: capture beats a software write landing in the same cycle
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         compare_capture_a <= TCC_CC_RST;
      else if ((mode_r == TCC_CAP_PINS) && b_edge_hi)
         compare_capture_a <= count_r;
      else if ((mode_r == TCC_CAP_TWO) && a_opposite)
         compare_capture_a <= count_r;
      else if (compare_a_write)
         compare_capture_a <= compare_a_data;
   end

   // Register B: capture beats a software write landing in the same cycle
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         compare_capture_b <= TCC_CC_RST;
      else if ((mode_r == TCC_CAP_ONE) && a_edge_hi)
         compare_capture_b <= count_r;
      else if (((mode_r == TCC_CAP_PINS) || (mode_r == TCC_CAP_TWO) || (mode_r == TCC_RESTART)) && a_edge_lo)
         compare_capture_b <= count_r;
      else if (compare_b_write)
         compare_capture_b <= compare_b_data;
   end

   // Interrupt request pulses, one cycle each
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         match_a_interrupt   <= 1'b0;
         capture_b_interrupt <= 1'b0;
      end
      else
      begin
         match_a_interrupt   <= match_hit || ((mode_r == TCC_CAP_PINS) && b_edge_hi);
         capture_b_interrupt <= ((mode_r == TCC_CAP_ONE) && a_edge_hi)
                             || (((mode_r == TCC_CAP_PINS) || (mode_r == TCC_CAP_TWO) || (mode_r == TCC_RESTART))
                                 && a_edge_lo);
      end
   end

   // Pulse output: active for counts 0..B of each 0..A cycle
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         timer_output_pin <= 1'b0;
      else
         timer_output_pin <= (mode_r == TCC_PPG) && (count_nxt <= compare_capture_b);
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);

   a_interval_clear: assert property ((mode_r == TCC_INTERVAL) && cnt_tick && (count_r == compare_capture_a)
                                      |=> (count_r == 16'h0000) && match_a_interrupt)
      else $error("interval match did not clear count with interrupt");
   a_interval_step: assert property ((mode_r == TCC_INTERVAL) && $stable(mode_r) && cnt_tick
                                     && (count_r != compare_capture_a) |=> count_r == $past(count_r) + 16'h0001)
      else $error("interval count did not step by one");
   a_free_wrap: assert property ((mode_r == TCC_CAP_ONE) && $stable(mode_r) && cnt_tick && (count_r == 16'hffff)
                                 |=> count_r == 16'h0000)
      else $error("free running count did not wrap");
   a_ppg_level: assert property ((mode_r == TCC_PPG) && $past(mode_r == TCC_PPG) && $stable(compare_capture_b)
                                 |-> timer_output_pin == (count_r <= compare_capture_b))
      else $error("pulse output level wrong for count");
   a_cap_one_b: assert property ((mode_r == TCC_CAP_ONE) && edge_ok(es_b, a_rise, a_fall)
                                 |=> (compare_capture_b == $past(count_r)) && capture_b_interrupt)
      else $error("single capture into B missing");
   a_pins_capture_a: assert property ((mode_r == TCC_CAP_PINS) && edge_ok(es_b, b_rise, b_fall)
                                      |=> (compare_capture_a == $past(count_r)) && match_a_interrupt)
      else $error("trigger B capture into A missing");
   a_restart_clear: assert property ((mode_r == TCC_RESTART) && edge_ok(es_a, a_rise, a_fall)
                                     |=> (count_r == 16'h0000) && (compare_capture_b == $past(count_r)))
      else $error("restart capture or clear missing");
   a_prohib_hold: assert property ((clk_sel == 3'h7) && (mode_r == TCC_CAP_ONE) && $stable(mode_r)
                                   |=> $stable(count_r))
      else $error("prohibited clock code still counts");
   a_two_reg_opp: assert property ((mode_r == TCC_CAP_TWO) && (es_a == 2'h1) && a_fall
                                   |=> compare_capture_a == $past(count_r))
      else $error("opposite edge capture into A missing");

   c_interval_match: cover property ((mode_r == TCC_INTERVAL) && match_hit ##1 match_a_interrupt);
   c_ppg_toggle: cover property ((mode_r == TCC_PPG) && timer_output_pin ##1 !timer_output_pin);
   c_restart_edge: cover property ((mode_r == TCC_RESTART) && capture_b_interrupt);
   c_pins_both: cover property ((mode_r == TCC_CAP_PINS) && capture_b_interrupt ##[1:50] match_a_interrupt);

endmodule

`default_nettype wire

// [tb/tcc_pulse_src.sv]
/*
   Model of the external pulse sources on the two trigger pins.
   Assumes callers sit just after a rising edge; every level change lands
   1 ns after an edge so that the filter sees a stable phase.
*/
`default_nettype none

module tcc_pulse_src
(
   input  wire logic clock,
   output var  logic trigger_input_a,
   output var  logic trigger_input_b
);
   timeunit 1ns;
   timeprecision 100ps;

   // Both sources idle low, as after a pulled-down line
   initial
   begin
      trigger_input_a = 1'b0;
      trigger_input_b = 1'b0;
   end

   // Set one pin to a level and keep it for a whole number of cycles
   task automatic hold(input logic pin_b, input logic level, input int cycles);
      @(posedge clock);
      #1;
      if (pin_b)
         trigger_input_b = level;
      else
         trigger_input_a = level;
      repeat (cycles - 1) @(posedge clock);
   endtask

   // Square wave on one pin; even half periods keep edge latency constant
   task automatic toggle(input logic pin_b, input int periods, input int half);
      for (int i = 0; i < periods; i++)
      begin
         hold(pin_b, 1'b1, half);
         hold(pin_b, 1'b0, half);
      end
   endtask
endmodule

`default_nettype wire

// [tb/tcc_timer_tb_top.sv]
/*
   Self-checking bench for the capture/compare timer: interval, pulse
   generator and capture modes. Assumes the pulse source model drives the
   trigger pins and that inputs change 1 ns after the rising edge.
*/
`default_nettype none

module tcc_timer_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import tcc_pkg::*;

   logic        clock;
   logic        rst_b;
   logic [2:0]  mode_control_register;
   logic [7:0]  prescaler_mode_a;
   logic [7:0]  prescaler_mode_b;
   logic        compare_a_write;
   logic [15:0] compare_a_data;
   logic        compare_b_write;
   logic [15:0] compare_b_data;
   logic        watch_timer_interrupt;
   logic        watch_en;
   wire logic   trigger_input_a;
   wire logic   trigger_input_b;
   logic [15:0] count_register;
   logic [15:0] compare_capture_a;
   logic [15:0] compare_capture_b;
   logic        match_a_interrupt;
   logic        capture_b_interrupt;
   logic        timer_output_pin;
   int          failures;
   int          compares;
   int          n_irq_a;
   int          n_irq_b;
   int          n;
   logic [15:0] last_cnt;
   logic [15:0] cap_b_q [$];
   bit          chk_zero;
   bit          cap_a_on;
   bit          restart_on;
   logic [2:0]  ck_code [7] = '{TCC_CK_DIV2, TCC_CK_DIV16, TCC_CK_WATCH, TCC_CK_TRIG_A,
                                 TCC_CK_DIV4, TCC_CK_DIV64, TCC_CK_DIV256};
   int          ck_div [7] = '{2, 16, 2, 8, 4, 64, 256};
   logic [1:0]  es_code [4] = '{TCC_ES_FALL, TCC_ES_RISE, TCC_ES_BOTH, 2'h2};
   int          es_hits [4] = '{1, 1, 2, 0};

   tcc_timer u_tcc_timer
   (
      .clock                 (clock),
      .rst_b                 (rst_b),
      .mode_control_register (mode_control_register),
      .prescaler_mode_a      (prescaler_mode_a),
      .prescaler_mode_b      (prescaler_mode_b),
      .compare_a_write       (compare_a_write),
      .compare_a_data        (compare_a_data),
      .compare_b_write       (compare_b_write),
      .compare_b_data        (compare_b_data),
      .trigger_input_a       (trigger_input_a),
      .trigger_input_b       (trigger_input_b),
      .watch_timer_interrupt (watch_timer_interrupt),
      .count_register        (count_register),
      .compare_capture_a     (compare_capture_a),
      .compare_capture_b     (compare_capture_b),
      .match_a_interrupt     (match_a_interrupt),
      .capture_b_interrupt   (capture_b_interrupt),
      .timer_output_pin      (timer_output_pin)
   );

   tcc_pulse_src u_tcc_pulse_src
   (
      .clock           (clock),
      .trigger_input_a (trigger_input_a),
      .trigger_input_b (trigger_input_b)
   );

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Watch tick source: one-cycle pulses every other cycle when enabled
   always @(posedge clock)
   begin
      #1;
      watch_timer_interrupt <= watch_en & ~watch_timer_interrupt;
   end

   // Interrupt monitor: every capture flagged by an interrupt must hold the count of the cycle before
   always @(posedge clock)
   begin
      #2;
      if (capture_b_interrupt === 1'b1)
      begin
         n_irq_b++;
         cap_b_q.push_back(compare_capture_b);
         check(compare_capture_b, last_cnt);
         if (restart_on) check(count_register, 16'h0000);
      end
      if (match_a_interrupt === 1'b1)
      begin
         n_irq_a++;
         if (chk_zero) check(count_register, 16'h0000);
         if (cap_a_on) check(compare_capture_a, last_cnt);
      end
      // Settled count of this cycle, used as the expectation one cycle on
      last_cnt = count_register;
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test;
      if (failures == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic step;
      @(posedge clock);
      #1;
   endtask

   // Stop, load prescalers and both registers, then start the new mode
   task automatic setup(input logic [2:0] m, input logic [7:0] pa, input logic [7:0] pb,
                        input logic [15:0] a_val, input logic [15:0] b_val);
      step();
      mode_control_register = TCC_MC_STOP;
      step();
      prescaler_mode_a = pa;
      prescaler_mode_b = pb;
      compare_a_write = 1'b1;
      compare_a_data = a_val;
      compare_b_write = 1'b1;
      compare_b_data = b_val;
      step();
      compare_a_write = 1'b0;
      compare_b_write = 1'b0;
      chk_zero = (m == TCC_MC_INTERVAL);
      cap_a_on = (m == TCC_MC_CAP_PINS);
      restart_on = (m == TCC_MC_RESTART);
      n_irq_a = 0;
      n_irq_b = 0;
      cap_b_q.delete();
      check({compare_capture_a, compare_capture_b}, {a_val, b_val});
      mode_control_register = m;
   endtask

   // Cycles between two consecutive match A interrupts, bounded
   task automatic gap(output int cyc);
      int k;
      k = 0;
      while (match_a_interrupt !== 1'b1 && k < 4000)
      begin
         step();
         k++;
      end
      step();
      cyc = 1;
      while (match_a_interrupt !== 1'b1 && cyc < 4000)
      begin
         step();
         cyc++;
      end
   endtask

   initial
   begin
      repeat (20000) @(posedge clock);
      failures++;
      end_of_test();
   end

   initial
   begin
      failures = 0;
      compares = 0;
      rst_b = 1'b0;
      mode_control_register = TCC_MC_STOP;
      prescaler_mode_a = TCC_PRE_RST;
      prescaler_mode_b = TCC_PRE_RST;
      compare_a_write = 1'b0;
      compare_a_data = 16'h0000;
      compare_b_write = 1'b0;
      compare_b_data = 16'h0000;
      watch_en = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      rst_b = 1'b1;
      step();
      check({count_register, compare_capture_a, compare_capture_b}, 48'h0);
      check({match_a_interrupt, capture_b_interrupt, timer_output_pin}, 3'h0);
      // Interval period for every count clock source, N = 2
      for (int i = 0; i < 7; i++)
      begin
         watch_en = (ck_code[i] == TCC_CK_WATCH);
         setup(TCC_MC_INTERVAL, {2'h0, TCC_ES_RISE, 2'h0, ck_code[i][1:0]},
               {7'h00, ck_code[i][2]}, 16'h0002, 16'h0000);
         fork
            u_tcc_pulse_src.toggle(1'b0, (ck_code[i] == TCC_CK_TRIG_A) ? 12 : 0, 4);
            gap(n);
         join
         check(n, 3 * ck_div[i]);
      end
      watch_en = 1'b0;
      // Pulse generator: period 8 counts, width 3 counts at /2
      setup(TCC_MC_PPG, 8'h00, 8'h00, 16'h0007, 16'h0002);
      gap(n);
      check(n, 16);
      n = 0;
      repeat (16)
      begin
         step();
         n += (timer_output_pin === 1'b1);
      end
      check(n, 6);
      // One capture register: edge field in bits 7:6, bits 5:4 left invalid
      for (int i = 0; i < 4; i++)
      begin
         setup(TCC_MC_CAP_ONE, {es_code[i], 2'h2, 4'h0}, 8'h00, 16'h0000, 16'h0000);
         u_tcc_pulse_src.hold(1'b0, 1'b1, 20);
         u_tcc_pulse_src.hold(1'b0, 1'b0, 20);
         check(n_irq_b, es_hits[i]);
         if (i == 2) check(16'(cap_b_q[1] - cap_b_q[0]), 16'h000a);
         u_tcc_pulse_src.hold(1'b0, 1'b1, 1);
         u_tcc_pulse_src.hold(1'b0, 1'b0, 20);
         check(n_irq_b, es_hits[i]);
      end
      // Two pins: A rising into B, B falling into A, 12 cycles apart
      setup(TCC_MC_CAP_PINS, {TCC_ES_FALL, TCC_ES_RISE, 4'h0}, 8'h00, 16'h0000, 16'h0000);
      u_tcc_pulse_src.hold(1'b1, 1'b1, 4);
      u_tcc_pulse_src.hold(1'b0, 1'b1, 12);
      u_tcc_pulse_src.hold(1'b1, 1'b0, 20);
      u_tcc_pulse_src.hold(1'b0, 1'b0, 20);
      check({n_irq_a, n_irq_b}, {32'd1, 32'd1});
      check(16'(compare_capture_a - compare_capture_b), 16'h0006);
      // Two registers: rising edge into B, opposite edge into A
      setup(TCC_MC_CAP_TWO, {2'h0, TCC_ES_RISE, 4'h0}, 8'h00, 16'h0000, 16'h0000);
      u_tcc_pulse_src.hold(1'b0, 1'b1, 16);
      u_tcc_pulse_src.hold(1'b0, 1'b0, 20);
      check({n_irq_a, n_irq_b}, {32'd0, 32'd1});
      check(16'(compare_capture_a - compare_capture_b), 16'h0008);
      // Restart: two rising edges, each capturing then clearing
      setup(TCC_MC_RESTART, {2'h0, TCC_ES_RISE, 4'h0}, 8'h00, 16'h0000, 16'h0000);
      u_tcc_pulse_src.toggle(1'b0, 2, 12);
      repeat (8) step();
      check(n_irq_b, 2);
      check(cap_b_q[1], 16'h000c);
      // Prohibited clock code: a free running mode must not count at all
      setup(TCC_MC_CAP_ONE, 8'h03, 8'h01, 16'h0000, 16'h0000);
      repeat (20) step();
      check(count_register, 16'h0000);
      end_of_test();
   end
endmodule

`default_nettype wire
